/* File: bench/tdm_connection_command_regs_tb.sv */
// Self-checking bench for the connection command register set
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value at %0t ns: got %h expected %h", \
                $time, got, exp); \
        end \
    end

module tdm_connection_command_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tdm_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = 5'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic cmd_pulse, cmd_src_bus, cmd_dst_bus, cmd_mp_and;
    conn_op_t cmd_op;
    logic [4:0] cmd_src_port, cmd_dst_port;
    logic [7:0] cmd_in_slot, cmd_out_slot, rv;
    logic [2:0] cmd_in_sub, cmd_out_sub, shift_bits;
    logic [3:0] cmd_slot_bits, fp_width;
    logic [15:0] ref_freq_khz, netref_freq_khz, programmable_clock_out_freq_khz;
    logic shift_after_sync, shift_edge_invert, fp_edge_invert;
    logic [10:0] fp_offset;
    int n_fail = 0;
    int tests_run = 0;
    logic [15:0] ref_tab [8] = '{16'h0008, 16'h0200, 16'h0600, 16'h0608,
        16'h0800, 16'h1000, 16'h2000, 16'h4000};
    logic [15:0] gp_tab [8] = '{16'h0008, 16'h0800, 16'h1000, 16'h2000,
        16'h4000, 16'h0800, 16'hC000, 16'h0000};
    logic [15:0] net_tab [4] = '{16'h0008, 16'h0200, 16'h0800, 16'h0000};

    tdm_connection_command_regs u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(clk_en), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .cmd_pulse(cmd_pulse), .cmd_op(cmd_op),
        .cmd_src_bus(cmd_src_bus), .cmd_src_port(cmd_src_port),
        .cmd_in_slot(cmd_in_slot), .cmd_dst_bus(cmd_dst_bus),
        .cmd_dst_port(cmd_dst_port), .cmd_out_slot(cmd_out_slot),
        .cmd_in_sub(cmd_in_sub), .cmd_out_sub(cmd_out_sub),
        .cmd_slot_bits(cmd_slot_bits), .cmd_mp_and(cmd_mp_and),
        .ref_freq_khz(ref_freq_khz), .netref_freq_khz(netref_freq_khz),
        .shift_bits(shift_bits), .shift_after_sync(shift_after_sync),
        .shift_edge_invert(shift_edge_invert), .fp_offset(fp_offset),
        .fp_width(fp_width), .fp_edge_invert(fp_edge_invert),
        .programmable_clock_out_freq_khz(programmable_clock_out_freq_khz));

    always #50 ref_clk = ~ref_clk;

    task automatic end_of_test;
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    // Each access starts one edge later, so strobes never toggle twice at once
    task automatic put(input logic [4:0] a, input logic [7:0] d);
        tick();
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
    endtask : put

    task automatic get(input logic [4:0] a, output logic [7:0] d);
        tick();
        addr = a;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        d = rdata;
    endtask : get

    task automatic t_reset;
        `CHK(cmd_pulse, 1'b0);
        `CHK(cmd_op, OP_NOP);
        `CHK(cmd_slot_bits, 4'h8);
        `CHK(ref_freq_khz, 16'h0008);
        `CHK(netref_freq_khz, 16'h0008);
        `CHK(programmable_clock_out_freq_khz, 16'h0008);
        `CHK(fp_width, 4'h1);
        for (int a = 0; a < 8; a++)
        begin
            get(5'(a), rv);
            `CHK(rv, 8'h00);
        end
    endtask : t_reset

    // Reserved bits read zero, unmapped addresses ignore writes
    task automatic t_masks;
        for (int a = 0; a < 9; a++)
        begin
            put(5'(a), 8'hFF);
            `CHK(cmd_pulse, 1'b0);
        end
        for (int a = 0; a < 10; a++)
        begin
            get(5'(a), rv);
            `CHK(rv, (a == 0 || a == 2) ? 8'h9F : a == 7 ? 8'h3F :
                a > 7 ? 8'h00 : 8'hFF);
        end
    endtask : t_masks

    task automatic t_freq;
        for (int c = 0; c < 8; c++)
        begin
            put(REG_OPND_LOW, 8'(c));
            tick();
            `CHK(ref_freq_khz, ref_tab[c]);
            `CHK(netref_freq_khz, net_tab[c % 4]);
            `CHK(programmable_clock_out_freq_khz, gp_tab[c]);
        end
    endtask : t_freq

    task automatic t_fields(input logic [7:0] lo, input logic [7:0] hi);
        put(REG_OPND_LOW, lo);
        put(REG_OPND_HIGH, hi);
        tick();
        `CHK(shift_bits, lo[3:1]);
        `CHK(shift_after_sync, lo[4]);
        `CHK(shift_edge_invert, lo[0]);
        `CHK(fp_offset, {hi[4:0], lo[7:2]});
        `CHK(fp_edge_invert, lo[1]);
        `CHK(fp_width, {1'b0, hi[7:5]} + 4'h1);
    endtask : t_fields

    task automatic t_cmd(input logic [3:0] c, input logic [3:0] q);
        logic msg, sub;
        msg = (c == 4'h3 || c == 4'h4);
        sub = (c == 4'h1 || c == 4'h5 || c == 4'h6);
        put(REG_COMMAND, {q, c});
        `CHK(cmd_pulse, 1'b1);
        `CHK(cmd_op, conn_op_t'(c));
        `CHK(cmd_src_bus, !msg);
        `CHK(cmd_src_port, msg ? 5'h00 : 5'h05);
        `CHK(cmd_in_slot, msg ? 8'h00 : 8'h3C);
        `CHK(cmd_dst_bus, 1'b0);
        `CHK(cmd_dst_port, 5'h1F);
        `CHK(cmd_out_slot, 8'hC3);
        `CHK(cmd_in_sub, sub ? 3'h2 : 3'h0);
        `CHK(cmd_out_sub, sub ? 3'h5 : 3'h0);
        `CHK(cmd_slot_bits, sub ? 4'h8 >> q[1:0] : 4'h8);
        `CHK(cmd_mp_and, c == 4'h7 && q[0]);
        tick();
        `CHK(cmd_pulse, 1'b0);
    endtask : t_cmd

    task automatic t_cmds;
        put(REG_SRC_PORT, 8'h85);
        put(REG_IN_SLOT, 8'h3C);
        put(REG_DST_PORT, 8'h1F);
        put(REG_OUT_SLOT, 8'hC3);
        put(REG_SUBCH, 8'h2A);
        for (int c = 1; c < 8; c++)
            t_cmd(4'(c), 4'hD);
        for (int q = 0; q < 4; q++)
            t_cmd(4'h6, 4'(q));
        t_cmd(4'h7, 4'h0);
        put(REG_COMMAND, 8'h30);
        `CHK(cmd_pulse, 1'b0);
        `CHK(cmd_op, OP_MULTIPOINT);
        put(REG_COMMAND, 8'h08);
        `CHK(cmd_pulse, 1'b0);
        get(REG_COMMAND, rv);
        `CHK(rv, 8'h08);
    endtask : t_cmds

    // Bits 6..5 are dropped, so the destination becomes bus 1, port 4
    task automatic t_b2b;
        put(REG_DST_PORT, 8'hE4);
        tick();
        addr = REG_COMMAND;
        wdata = 8'h02;
        wr = 1'b1;
        tick();
        wdata = 8'h26;
        `CHK(cmd_pulse, 1'b1);
        `CHK(cmd_op, OP_CONNECT_MIN);
        tick();
        wr = 1'b0;
        `CHK(cmd_pulse, 1'b1);
        `CHK(cmd_op, OP_DROP_BCAST);
        `CHK(cmd_slot_bits, 4'h2);
        `CHK(cmd_dst_bus, 1'b1);
        `CHK(cmd_dst_port, 5'h04);
    endtask : t_b2b

    // A write while the enable is low must not land; the pulse holds
    task automatic t_freeze;
        put(REG_COMMAND, 8'h01);
        clk_en = 1'b0;
        put(REG_OUT_SLOT, 8'h5A);
        `CHK(cmd_pulse, 1'b1);
        clk_en = 1'b1;
        get(REG_OUT_SLOT, rv);
        `CHK(rv, 8'hC3);
        `CHK(cmd_pulse, 1'b0);
    endtask : t_freeze

    initial
    begin
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_masks();
        t_freq();
        t_fields(8'hB7, 8'hA5);
        t_fields(8'h48, 8'hFF);
        t_cmds();
        t_b2b();
        t_freeze();
        tick();
        rst_b = 1'b0;
        repeat (2) tick();
        rst_b = 1'b1;
        t_reset();
        end_of_test();
    end
endmodule : tdm_connection_command_regs_tb

/* File: rtl/tdm_connection_command_regs.sv */
// Connection command and parameter registers with operand decoding
module tdm_connection_command_regs (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [tdm_cmd_pkg::ADDR_W-1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [tdm_cmd_pkg::DATA_W-1:0] wdata,
    output logic [tdm_cmd_pkg::DATA_W-1:0] rdata,
    output logic cmd_pulse,
    output tdm_cmd_pkg::conn_op_t cmd_op,
    output logic cmd_src_bus,
    output logic [4:0] cmd_src_port,
    output logic [7:0] cmd_in_slot,
    output logic cmd_dst_bus,
    output logic [4:0] cmd_dst_port,
    output logic [7:0] cmd_out_slot,
    output logic [2:0] cmd_in_sub,
    output logic [2:0] cmd_out_sub,
    output logic [3:0] cmd_slot_bits,
    output logic cmd_mp_and,
    output logic [15:0] ref_freq_khz,
    output logic [15:0] netref_freq_khz,
    output logic [2:0] shift_bits,
    output logic shift_after_sync,
    output logic shift_edge_invert,
    output logic [10:0] fp_offset,
    output logic [3:0] fp_width,
    output logic fp_edge_invert,
    output logic [15:0] programmable_clock_out_freq_khz
);
    import tdm_cmd_pkg::*;

    logic [7:0] regs [0:REG_COUNT-1];
    logic reg_hit;
    logic cmd_write;
    logic [3:0] next_code;
    logic [3:0] next_qual;
    logic next_issue;

    // Bits that hold storage per register; the rest read as zero
    function automatic logic [7:0] reg_mask(input logic [2:0] idx);
        case (idx)
            REG_SRC_PORT[2:0]: reg_mask = PORT_MASK;
            REG_DST_PORT[2:0]: reg_mask = PORT_MASK;
            REG_SUBCH[2:0]: reg_mask = SUBCH_MASK;
            default: reg_mask = FULL_MASK;
        endcase
    endfunction : reg_mask

    function automatic logic [3:0] slot_bits(input logic [1:0] q);
        case (q)
            2'h0: slot_bits = 4'h8;
            2'h1: slot_bits = 4'h4;
            2'h2: slot_bits = 4'h2;
            default: slot_bits = 4'h1;
        endcase
    endfunction : slot_bits

    function automatic logic [15:0] ref_khz(input logic [2:0] c);
        case (c)
            3'h0: ref_khz = KHZ_8;
            3'h1: ref_khz = KHZ_512;
            3'h2: ref_khz = KHZ_1536;
            3'h3: ref_khz = KHZ_1544;
            3'h4: ref_khz = KHZ_2048;
            3'h5: ref_khz = KHZ_4096;
            3'h6: ref_khz = KHZ_8192;
            default: ref_khz = KHZ_16384;
        endcase
    endfunction : ref_khz

    assign reg_hit = (addr < ADDR_W'(REG_COUNT));
    assign cmd_write = clk_en && wr && (addr == REG_COMMAND);

    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++)
        begin : g_reg
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    regs[gi] <= RESET_VAL;
                else if (clk_en && wr && addr == ADDR_W'(gi))
                    regs[gi] <= wdata & reg_mask(3'(gi));
            end
        end
    endgenerate

    // Read data is registered, so it follows the read strobe by one cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= RESET_VAL;
        else if (clk_en && rd)
            rdata <= reg_hit ? regs[addr[2:0]] : RESET_VAL;
    end

    // Command is taken from the write data, so parameters written earlier
    // and the code written now go out together in one pulse
    always_comb
    begin
        next_code = wdata[3:0];
        next_qual = wdata[7:QUAL_LSB];
        case (next_code)
            OP_CONNECT_CONST, OP_CONNECT_MIN, OP_SEND_MSG, OP_STOP_MSG,
            OP_DISCONNECT, OP_DROP_BCAST, OP_MULTIPOINT:
                next_issue = cmd_write;
            default:
                next_issue = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cmd_pulse <= 1'b0;
        else if (clk_en)
            cmd_pulse <= next_issue;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_op <= OP_NOP;
            cmd_src_bus <= 1'b0;
            cmd_src_port <= 5'h00;
            cmd_in_slot <= 8'h00;
            cmd_dst_bus <= 1'b0;
            cmd_dst_port <= 5'h00;
            cmd_out_slot <= 8'h00;
            cmd_in_sub <= 3'h0;
            cmd_out_sub <= 3'h0;
            cmd_slot_bits <= 4'h8;
            cmd_mp_and <= 1'b0;
        end
        else if (clk_en && next_issue)
        begin
            cmd_op <= conn_op_t'(next_code);
            // Destination is used by every command
            cmd_dst_bus <= regs[REG_DST_PORT[2:0]][BUS_BIT];
            cmd_dst_port <= regs[REG_DST_PORT[2:0]][4:0];
            cmd_out_slot <= regs[REG_OUT_SLOT[2:0]];
            cmd_slot_bits <= 4'h8;
            cmd_mp_and <= 1'b0;
            cmd_in_sub <= 3'h0;
            cmd_out_sub <= 3'h0;
            cmd_src_bus <= 1'b0;
            cmd_src_port <= 5'h00;
            cmd_in_slot <= 8'h00;
            case (next_code)
                OP_CONNECT_CONST, OP_DISCONNECT, OP_DROP_BCAST:
                begin
                    cmd_src_bus <= regs[REG_SRC_PORT[2:0]][BUS_BIT];
                    cmd_src_port <= regs[REG_SRC_PORT[2:0]][4:0];
                    cmd_in_slot <= regs[REG_IN_SLOT[2:0]];
                    cmd_in_sub <= regs[REG_SUBCH[2:0]][2:0];
                    cmd_out_sub <= regs[REG_SUBCH[2:0]][5:SUB_OUT_LSB];
                    cmd_slot_bits <= slot_bits(next_qual[1:0]);
                end
                OP_CONNECT_MIN, OP_MULTIPOINT:
                begin
                    cmd_src_bus <= regs[REG_SRC_PORT[2:0]][BUS_BIT];
                    cmd_src_port <= regs[REG_SRC_PORT[2:0]][4:0];
                    cmd_in_slot <= regs[REG_IN_SLOT[2:0]];
                    cmd_mp_and <= (next_code == OP_MULTIPOINT)
                        && next_qual[0];
                end
                default:
                begin
                    // Message commands name only the destination
                    cmd_mp_and <= 1'b0;
                end
            endcase
        end
    end

    // Operand views follow the operand registers one cycle later
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_freq_khz <= KHZ_8;
            netref_freq_khz <= KHZ_8;
            programmable_clock_out_freq_khz <= KHZ_8;
        end
        else if (clk_en)
        begin
            ref_freq_khz <= ref_khz(regs[REG_OPND_LOW[2:0]][2:0]);
            case (regs[REG_OPND_LOW[2:0]][1:0])
                2'h0: netref_freq_khz <= KHZ_8;
                2'h1: netref_freq_khz <= KHZ_512;
                2'h2: netref_freq_khz <= KHZ_2048;
                default: netref_freq_khz <= KHZ_NONE;
            endcase
            case (regs[REG_OPND_LOW[2:0]][2:0])
                3'h0: programmable_clock_out_freq_khz <= KHZ_8;
                3'h1: programmable_clock_out_freq_khz <= KHZ_2048;
                3'h2: programmable_clock_out_freq_khz <= KHZ_4096;
                3'h3: programmable_clock_out_freq_khz <= KHZ_8192;
                3'h4: programmable_clock_out_freq_khz <= KHZ_16384;
                3'h5: programmable_clock_out_freq_khz <= KHZ_2048;
                3'h6: programmable_clock_out_freq_khz <= KHZ_49152;
                default: programmable_clock_out_freq_khz <= KHZ_NONE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_bits <= 3'h0;
            shift_after_sync <= 1'b0;
            shift_edge_invert <= 1'b0;
        end
        else if (clk_en)
        begin
            shift_bits <= regs[REG_OPND_LOW[2:0]][3:SHIFT_LSB];
            shift_after_sync <= regs[REG_OPND_LOW[2:0]][SHIFT_SIDE_BIT];
            shift_edge_invert <= regs[REG_OPND_LOW[2:0]][0];
        end
    end

    // Bit 0 of the low operand is the shift edge invert and is ignored by the frame pulse
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fp_offset <= 11'h000;
            fp_width <= 4'h1;
            fp_edge_invert <= 1'b0;
        end
        else if (clk_en)
        begin
            fp_offset <= {regs[REG_OPND_HIGH[2:0]][4:0],
                regs[REG_OPND_LOW[2:0]][7:FP_LOW_LSB]};
            fp_width <= {1'b0, regs[REG_OPND_HIGH[2:0]][7:FP_WIDTH_LSB]}
                + 4'h1;
            fp_edge_invert <= regs[REG_OPND_LOW[2:0]][FP_EDGE_BIT];
        end
    end

    sequence s_cmd_write(logic [3:0] c);
        clk_en && wr && addr == REG_COMMAND && wdata[3:0] == c;
    endsequence

    sequence s_pulse_out(logic [3:0] c);
        cmd_pulse && cmd_op == conn_op_t'(c);
    endsequence

    chk_nop_silent: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h0) |=> !cmd_pulse)
        else $error("no-operation code produced a command pulse");

    chk_const_issue: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h1) |=> s_pulse_out(4'h1) and
            (cmd_in_slot == $past(regs[1])
            && cmd_slot_bits == slot_bits($past(wdata[5:4]))))
        else $error("constant delay connect not issued correctly");

    chk_min_nosub: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h2) |=> s_pulse_out(4'h2) and
            (cmd_in_sub == 3'h0 && cmd_out_sub == 3'h0))
        else $error("minimum delay connect carried subchannels");

    chk_msg_dest: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h3) |=> s_pulse_out(4'h3) and
            (cmd_out_slot == $past(regs[3]) && cmd_src_port == 5'h00))
        else $error("send message not aimed at destination slot");

    chk_stop_dest: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h4) |=> s_pulse_out(4'h4) and
            (cmd_out_slot == $past(regs[3]) && cmd_in_slot == 8'h00))
        else $error("stop message not aimed at destination slot");

    chk_disc_issue: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h5) |=> s_pulse_out(4'h5) and
            (cmd_in_sub == $past(regs[7][2:0])
            && cmd_out_sub == $past(regs[7][5:3])
            && cmd_slot_bits == slot_bits($past(wdata[5:4]))))
        else $error("disconnect fields not issued correctly");

    chk_drop_issue: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h6) |=> s_pulse_out(4'h6) and
            (cmd_src_port == $past(regs[0][4:0])
            && cmd_dst_port == $past(regs[2][4:0])))
        else $error("broadcast drop addresses wrong");

    chk_mp_mode: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_cmd_write(4'h7) |=> s_pulse_out(4'h7) and
            (cmd_mp_and == $past(wdata[4])))
        else $error("multipoint combine mode wrong");

    chk_pulse_single: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en ##1 cmd_pulse |-> $past(next_issue))
        else $error("command pulse without a command write");

    chk_ref_decode: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && regs[4][2:0] == 3'h3 |=> ref_freq_khz == KHZ_1544)
        else $error("reference frequency decoded wrongly");

    chk_netref_decode: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && regs[4][1:0] == 2'h1 |=> netref_freq_khz == KHZ_512)
        else $error("network reference frequency decoded wrongly");

    chk_programmable_clock_out_decode: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && regs[4][2:0] == 3'h6 |=> programmable_clock_out_freq_khz == KHZ_49152)
        else $error("clock output source decoded wrongly");

    chk_port_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (regs[0][6:5] == 2'h0) && (regs[2][6:5] == 2'h0)
            && (regs[7][7:6] == 2'h0))
        else $error("port or subchannel reserved bits stored");

    chk_read_back: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && rd && addr == REG_SUBCH ##1 1'b1
            |-> (rdata & ~reg_mask(3'h7)) == 8'h00)
        else $error("subchannel read shows reserved bits");

    chk_fp_width: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en ##1 clk_en |-> fp_width
            == 4'(3'($past(regs[5]) >> FP_WIDTH_LSB)) + 4'h1)
        else $error("frame pulse width not field plus one");

    chk_fp_offset: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en ##1 clk_en |-> fp_offset
            == {$past(regs[5][4:0]), $past(regs[4][7:2])})
        else $error("frame pulse offset assembled wrongly");

    chk_shift_fields: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en ##1 clk_en |-> shift_bits == $past(regs[4][3:1])
            && shift_after_sync == $past(regs[4][4]))
        else $error("bit shift fields wrong");
endmodule : tdm_connection_command_regs

/* File: shared/tdm_cmd_pkg.sv */
// Constants and types of the connection command register set
package tdm_cmd_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 8;
    localparam logic [4:0] REG_SRC_PORT = 5'h00;
    localparam logic [4:0] REG_IN_SLOT = 5'h01;
    localparam logic [4:0] REG_DST_PORT = 5'h02;
    localparam logic [4:0] REG_OUT_SLOT = 5'h03;
    localparam logic [4:0] REG_OPND_LOW = 5'h04;
    localparam logic [4:0] REG_OPND_HIGH = 5'h05;
    localparam logic [4:0] REG_COMMAND = 5'h06;
    localparam logic [4:0] REG_SUBCH = 5'h07;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] PORT_MASK = 8'h9F;
    localparam logic [7:0] SUBCH_MASK = 8'h3F;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam int BUS_BIT = 7;
    localparam int SUB_OUT_LSB = 3;
    localparam int QUAL_LSB = 4;
    localparam int SHIFT_LSB = 1;
    localparam int SHIFT_SIDE_BIT = 4;
    localparam int FP_EDGE_BIT = 1;
    localparam int FP_LOW_LSB = 2;
    localparam int FP_WIDTH_LSB = 5;
    localparam logic [15:0] KHZ_8 = 16'h0008;
    localparam logic [15:0] KHZ_512 = 16'h0200;
    localparam logic [15:0] KHZ_1536 = 16'h0600;
    localparam logic [15:0] KHZ_1544 = 16'h0608;
    localparam logic [15:0] KHZ_2048 = 16'h0800;
    localparam logic [15:0] KHZ_4096 = 16'h1000;
    localparam logic [15:0] KHZ_8192 = 16'h2000;
    localparam logic [15:0] KHZ_16384 = 16'h4000;
    localparam logic [15:0] KHZ_49152 = 16'hC000;
    localparam logic [15:0] KHZ_NONE = 16'h0000;
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_CONNECT_CONST = 4'b0001,
        OP_CONNECT_MIN = 4'b0010,
        OP_SEND_MSG = 4'b0011,
        OP_STOP_MSG = 4'b0100,
        OP_DISCONNECT = 4'b0101,
        OP_DROP_BCAST = 4'b0110,
        OP_MULTIPOINT = 4'b0111
    } conn_op_t;
endpackage : tdm_cmd_pkg
